// *** rtl/pfg_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pfg_cfg.svh"
module pfg_top (
	input wire logic core_clk, // PWM clock
	input wire logic sys_rst, // Sync reset, high
	input wire logic clk_en, // Freezes all state when low
	input wire logic [3:0] ext_fault_in, // External fault pins
	input wire logic [7:0] dcmp_trig_in, // Digital comparator triggers
	input wire logic [15:0] fault_input_active_high, // Per gen x pin sense, 1=high
	input wire logic [3:0] min_fault_period_mode, // Per gen stretch enable
	input wire logic [63:0] min_fault_period_value, // Per gen period, 16 bits each
	input wire logic [3:0] extended_fault_source_mode, // Per gen extended select
	input wire logic [3:0] fault_latched_mode, // Per gen latched status
	input wire logic [3:0] sel_wr, // Per gen mask write strobe
	input wire logic [3:0] sel_grp0_wdata, // Group zero mask data
	input wire logic [7:0] sel_grp1_wdata, // Group one mask data
	input wire logic [3:0] latched_fault_clear_action, // Per gen clear strobe
	input wire logic [3:0] clr_grp0, // Group zero clear bits
	input wire logic [7:0] clr_grp1, // Group one clear bits
	input wire logic [23:0] irq_event, // Per gen counter events
	input wire logic [23:0] irq_en, // Per gen source enables
	input wire logic [23:0] irq_clr, // Per gen write-one-to-clear
	input wire logic [3:0] gen_int_en, // Module level enables
	output logic [15:0] fault_status_grp0, // Per gen group zero status
	output logic [31:0] fault_status_grp1, // Per gen group one status
	output logic [15:0] sel_grp0_rd, // Per gen group zero selection
	output logic [31:0] sel_grp1_rd, // Per gen group one selection
	output logic [3:0] gen_fault, // Per gen fault
	output logic [23:0] irq_raw, // Per gen raw status
	output logic [23:0] irq_masked, // Per gen masked status
	output logic [3:0] irq_line // Per gen interrupt line
);
	// ==========================================
	// Per generator logic
	genvar g;
	generate
		for (g = 0; g < `PFG_NUM_GEN; g++)
		begin : gen_g
			logic [3:0] sel0_r;
			logic [3:0] sel0_nxt;
			logic [7:0] sel1_r;
			logic [7:0] sel1_nxt;
			logic [3:0] lat0_r;
			logic [3:0] lat0_nxt;
			logic [7:0] lat1_r;
			logic [7:0] lat1_nxt;
			logic [3:0] ext_adj;
			logic [3:0] eff0;
			logic [7:0] eff1;
			logic [3:0] stat0_r;
			logic [3:0] stat0_nxt;
			logic [7:0] stat1_r;
			logic [7:0] stat1_nxt;
			logic raw_fault;
			assign ext_adj = ~(ext_fault_in ^ fault_input_active_high[g*4 +: 4]);
			// Selection masks and latches
			always_comb
			begin
				sel0_nxt = sel0_r;
				sel1_nxt = sel1_r;
				if (sel_wr[g])
				begin
					sel0_nxt = sel_grp0_wdata;
					sel1_nxt = sel_grp1_wdata;
				end
				lat0_nxt = lat0_r;
				lat1_nxt = lat1_r;
				if (latched_fault_clear_action[g])
				begin
					lat0_nxt = lat0_nxt & ~clr_grp0;
					lat1_nxt = lat1_nxt & ~clr_grp1;
				end
				lat0_nxt = lat0_nxt | ext_adj;
				lat1_nxt = lat1_nxt | dcmp_trig_in;
				stat0_nxt = fault_latched_mode[g] ? lat0_nxt : ext_adj;
				stat1_nxt = fault_latched_mode[g] ? lat1_nxt : dcmp_trig_in;
			end
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					sel0_r <= `PFG_GRP0_SEL_RST;
					sel1_r <= 8'h00;
					lat0_r <= 4'h0;
					lat1_r <= 8'h00;
					stat0_r <= 4'h0;
					stat1_r <= 8'h00;
				end
				else if (clk_en)
				begin
					sel0_r <= sel0_nxt;
					sel1_r <= sel1_nxt;
					lat0_r <= lat0_nxt;
					lat1_r <= lat1_nxt;
					stat0_r <= stat0_nxt;
					stat1_r <= stat1_nxt;
				end
			end
			assign eff0 = extended_fault_source_mode[g] ? sel0_r : 4'h1;
			assign eff1 = extended_fault_source_mode[g] ? sel1_r : 8'h00;
			assign raw_fault = |(ext_adj & eff0) | |(dcmp_trig_in & eff1);
			assign fault_status_grp0[g*4 +: 4] = stat0_r;
			assign fault_status_grp1[g*8 +: 8] = stat1_r;
			assign sel_grp0_rd[g*4 +: 4] = sel0_r;
			assign sel_grp1_rd[g*8 +: 8] = sel1_r;
			pfg_stretch u_str (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.clk_en(clk_en),
				.fault_in(raw_fault),
				.min_fault_period_mode(min_fault_period_mode[g]),
				.min_fault_period_value(min_fault_period_value[g*16 +: 16]),
				.fault_out(gen_fault[g])
			);
			pfg_irq u_irq (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.clk_en(clk_en),
				.irq_event(irq_event[g*6 +: 6]),
				.irq_en(irq_en[g*6 +: 6]),
				.irq_clr(irq_clr[g*6 +: 6]),
				.gen_int_en(gen_int_en[g]),
				.irq_raw(irq_raw[g*6 +: 6]),
				.irq_masked(irq_masked[g*6 +: 6]),
				.irq_line(irq_line[g])
			);
			property p_legacy;
				@(posedge core_clk) disable iff (sys_rst)
				(!extended_fault_source_mode[g] && !ext_adj[0]) |-> !raw_fault;
			endproperty
			a_legacy: assert property (p_legacy) else $error("legacy fault source");
			property p_latch_hold;
				@(posedge core_clk) disable iff (sys_rst)
				(clk_en && lat0_r[1] && !latched_fault_clear_action[g]) |=> lat0_r[1];
			endproperty
			a_latch_hold: assert property (p_latch_hold) else $error("latch released");
			property p_unlat;
				@(posedge core_clk) disable iff (sys_rst)
				(clk_en && !fault_latched_mode[g]) |=> stat1_r == $past(dcmp_trig_in);
			endproperty
			a_unlat: assert property (p_unlat) else $error("live status wrong");
			property p_or;
				@(posedge core_clk) disable iff (sys_rst)
				(extended_fault_source_mode[g] && |(dcmp_trig_in & sel1_r)) |-> gen_fault[g];
			endproperty
			a_or: assert property (p_or) else $error("selected trigger missed");
			c_latch: cover property (@(posedge core_clk) disable iff (sys_rst)
				fault_latched_mode[g] && stat0_r != 4'h0 && ext_adj == 4'h0);
			c_ext: cover property (@(posedge core_clk) disable iff (sys_rst)
				extended_fault_source_mode[g] && gen_fault[g]);
		end
	endgenerate
endmodule
`default_nettype wire

// *** shared/pfg_cfg.svh ***
`ifndef PFG_CFG_SVH
`define PFG_CFG_SVH
// ==========================================
// Sizes
`define PFG_NUM_GEN 4
`define PFG_NUM_EXT 4
`define PFG_NUM_DCMP 8
`define PFG_NUM_IRQ 6
`define PFG_PER_W 16
// ==========================================
// Interrupt source bit positions
`define PFG_IRQ_ZERO_BIT 0
`define PFG_IRQ_LOAD_BIT 1
`define PFG_IRQ_AU_BIT 2
`define PFG_IRQ_AD_BIT 3
`define PFG_IRQ_BU_BIT 4
`define PFG_IRQ_BD_BIT 5
// ==========================================
// Reset values
`define PFG_GRP0_SEL_RST 4'h1
`define PFG_PER_RST 16'h0000
`endif

// *** shared/pfg_pkg.sv ***
package pfg_pkg;
	// Fault stretch state
	typedef enum logic [0:0] {
		PFG_IDLE = 1'b0,
		PFG_HOLD = 1'b1
	} pfg_state_t;
endpackage

// *** rtl/pfg_irq.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pfg_cfg.svh"
// ==========================================
// Per-generator counter interrupt status
module pfg_irq (
	input wire logic core_clk, // Clock
	input wire logic sys_rst, // Sync reset
	input wire logic clk_en, // Clock enable
	input wire logic [5:0] irq_event, // Source events, pulses
	input wire logic [5:0] irq_en, // Source enables
	input wire logic [5:0] irq_clr, // Write-one-to-clear
	input wire logic gen_int_en, // Module level enable
	output logic [5:0] irq_raw, // Raw status
	output logic [5:0] irq_masked, // Masked status
	output logic irq_line // Interrupt line
);
	logic [5:0] stat_r;
	logic [5:0] stat_nxt;
	// Set wins over clear; zero bits leave state alone
	always_comb
	begin
		stat_nxt = (stat_r & ~irq_clr) | irq_event;
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			stat_r <= 6'h00;
		else if (clk_en)
			stat_r <= stat_nxt;
	end
	assign irq_raw = stat_r;
	assign irq_masked = stat_r & irq_en;
	assign irq_line = gen_int_en & (|irq_masked);
	// Assertions
	property p_irq_clear;
		@(posedge core_clk) disable iff (sys_rst)
		(clk_en && irq_clr[0] && !irq_event[0]) |=> !irq_raw[0];
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("clear lost");
	property p_irq_line;
		@(posedge core_clk) disable iff (sys_rst)
		irq_line |-> (gen_int_en && (|(irq_raw & irq_en)));
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("bad irq line");
	property p_irq_set;
		@(posedge core_clk) disable iff (sys_rst)
		(clk_en && irq_event[1]) |=> irq_raw[1];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("event lost");
	property p_irq_mask;
		@(posedge core_clk) disable iff (sys_rst)
		irq_masked == (irq_raw & irq_en);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("mask wrong");
	c_irq_fire: cover property (@(posedge core_clk) disable iff (sys_rst) irq_line);
endmodule
`default_nettype wire

// *** rtl/pfg_stretch.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pfg_cfg.svh"
// ==========================================
// Minimum fault period stretcher
module pfg_stretch (
	input wire logic core_clk, // Clock
	input wire logic sys_rst, // Sync reset
	input wire logic clk_en, // Clock enable
	input wire logic fault_in, // Combined raw fault
	input wire logic min_fault_period_mode, // Stretch enable
	input wire logic [15:0] min_fault_period_value, // Cycles
	output logic fault_out // Stretched fault
);
	pfg_pkg::pfg_state_t st_r;
	pfg_pkg::pfg_state_t st_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	// Load counter on new fault, count down while held
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			pfg_pkg::PFG_IDLE:
			begin
				if (fault_in && min_fault_period_mode && min_fault_period_value > 16'h0001)
				begin
					st_nxt = pfg_pkg::PFG_HOLD;
					cnt_nxt = min_fault_period_value - 16'h0002;
				end
			end
			pfg_pkg::PFG_HOLD:
			begin
				if (cnt_r == 16'h0000)
					st_nxt = pfg_pkg::PFG_IDLE;
				else
					cnt_nxt = cnt_r - 16'h0001;
			end
			default: st_nxt = pfg_pkg::PFG_IDLE;
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_r <= pfg_pkg::PFG_IDLE;
			cnt_r <= `PFG_PER_RST;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign fault_out = fault_in | (st_r == pfg_pkg::PFG_HOLD);
	property p_hold;
		@(posedge core_clk) disable iff (sys_rst)
		(st_r == pfg_pkg::PFG_HOLD) |-> fault_out;
	endproperty
	a_hold: assert property (p_hold) else $error("fault dropped in hold");
	property p_nostretch;
		@(posedge core_clk) disable iff (sys_rst)
		(st_r == pfg_pkg::PFG_IDLE && !(fault_in && min_fault_period_mode)) |=>
			(st_r == pfg_pkg::PFG_IDLE) || !clk_en;
	endproperty
	a_nostretch: assert property (p_nostretch) else $error("stretch without mode");
	property p_min2;
		@(posedge core_clk) disable iff (sys_rst)
		($rose(fault_out) && min_fault_period_mode && min_fault_period_value > 16'h0001
			&& clk_en) |=> fault_out;
	endproperty
	a_min2: assert property (p_min2) else $error("minimum period short");
	c_hold: cover property (@(posedge core_clk) disable iff (sys_rst)
		st_r == pfg_pkg::PFG_HOLD && !fault_in);
endmodule
`default_nettype wire

// *** dv/pfg_src_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Fault pin and comparator trigger source
module pfg_src_model (
	input wire logic [3:0] pin_req, // Commanded pin levels
	input wire logic [7:0] dcmp_req, // Commanded trigger levels
	output logic [3:0] ext_fault_in, // Fault pins
	output logic [7:0] dcmp_trig_in // Comparator triggers
);
	// Pins are always driven, so they never float
	assign ext_fault_in = pin_req;
	assign dcmp_trig_in = dcmp_req;
endmodule
`default_nettype wire

// *** dv/pfg_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module pfg_top_tb;
	typedef struct packed {logic xm; logic [3:0] sn; logic [3:0] a; logic [7:0] b;
		logic [3:0] pin; logic [7:0] dc; logic f; logic [3:0] s0;} pfg_row_t;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [3:0] pin_req = 4'h0;
	logic [7:0] dcmp_req = 8'h00;
	logic [3:0] ext_fault_in;
	logic [7:0] dcmp_trig_in;
	logic [15:0] sense = 16'hFFFF;
	logic [3:0] pmode = 4'h0;
	logic [3:0] xmode = 4'h0;
	logic [3:0] lmode = 4'h0;
	logic [3:0] sel_wr = 4'h0;
	logic [3:0] fclr = 4'h0;
	logic [63:0] pval = 64'h0;
	logic [3:0] m0 = 4'h0;
	logic [3:0] c0 = 4'h0;
	logic [7:0] m1 = 8'h00;
	logic [7:0] c1 = 8'h00;
	logic [23:0] ev = 24'h0;
	logic [23:0] en = 24'h0;
	logic [23:0] iclr = 24'h0;
	logic [3:0] gie = 4'h0;
	logic [15:0] st0, s0rd;
	logic [31:0] st1, s1rd;
	logic [3:0] flt, line;
	logic [23:0] raw, msk;
	int mismatches = 0;
	int checked = 0;
	pfg_row_t rows [9] = '{
		{1'b0, 4'hF, 4'hE, 8'hFF, 4'h1, 8'h00, 1'b1, 4'h1},
		{1'b0, 4'hF, 4'hE, 8'hFF, 4'h0, 8'hFF, 1'b0, 4'h0},
		{1'b0, 4'hE, 4'hE, 8'hFF, 4'h0, 8'h00, 1'b1, 4'h1},
		{1'b0, 4'hF, 4'hE, 8'hFF, 4'hE, 8'h00, 1'b0, 4'hE},
		{1'b1, 4'hF, 4'h4, 8'h00, 4'h4, 8'h00, 1'b1, 4'h4},
		{1'b1, 4'hF, 4'h4, 8'h00, 4'h1, 8'h00, 1'b0, 4'h1},
		{1'b1, 4'hF, 4'h0, 8'h10, 4'h0, 8'h10, 1'b1, 4'h0},
		{1'b1, 4'hF, 4'h0, 8'h10, 4'h0, 8'h08, 1'b0, 4'h0},
		{1'b1, 4'h7, 4'h8, 8'h00, 4'h0, 8'h00, 1'b1, 4'h8}};
	// Clock, 20 ns period
	always #10 core_clk = ~core_clk;
	pfg_src_model i_src (.pin_req(pin_req), .dcmp_req(dcmp_req), .ext_fault_in(ext_fault_in),
		.dcmp_trig_in(dcmp_trig_in));
	pfg_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(ce),
		.ext_fault_in(ext_fault_in), .dcmp_trig_in(dcmp_trig_in),
		.fault_input_active_high(sense), .min_fault_period_mode(pmode),
		.min_fault_period_value(pval), .extended_fault_source_mode(xmode),
		.fault_latched_mode(lmode), .sel_wr(sel_wr), .sel_grp0_wdata(m0), .sel_grp1_wdata(m1),
		.latched_fault_clear_action(fclr), .clr_grp0(c0), .clr_grp1(c1), .irq_event(ev),
		.irq_en(en), .irq_clr(iclr), .gen_int_en(gie), .fault_status_grp0(st0),
		.fault_status_grp1(st1), .sel_grp0_rd(s0rd), .sel_grp1_rd(s1rd), .gen_fault(flt),
		.irq_raw(raw), .irq_masked(msk), .irq_line(line));
	// Compare one result
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Clear-strobe pulse of one cycle
	task automatic clr_pulse();
		fclr = 4'h1;
		cyc(1);
		fclr = 4'h0;
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#400000;
		mismatches++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		cyc(8);
		sys_rst = 1'b0;
		cyc(1);
		chk(s0rd, 16'h1111);
		chk(s1rd, 32'h0);
		chk(st0, 16'h0);
		chk(raw, 24'h0);
		// Table of selection and sense cases on generator zero
		foreach (rows[i])
		begin
			xmode = {3'h0, rows[i].xm};
			sense[3:0] = rows[i].sn;
			pin_req = rows[i].pin;
			dcmp_req = rows[i].dc;
			m0 = rows[i].a;
			m1 = rows[i].b;
			sel_wr = 4'h1;
			cyc(1);
			sel_wr = 4'h0;
			cyc(1);
			chk(flt[0], rows[i].f);
			chk({s0rd[3:0], s1rd[7:0]}, {rows[i].a, rows[i].b});
			chk({st0[3:0], st1[7:0]}, {rows[i].s0, rows[i].dc});
		end
		// Stretch of a one-cycle fault to five cycles
		xmode = 4'h0;
		sense[3:0] = 4'hF;
		dcmp_req = 8'h00;
		pval[15:0] = 16'h0005;
		pmode = 4'h1;
		pin_req = 4'h1;
		for (int i = 0; i < 5; i++)
		begin
			#1 chk(flt[0], 1'b1);
			cyc(1);
			pin_req = 4'h0;
		end
		#1 chk(flt[0], 1'b0);
		cyc(2);
		chk(flt[0], 1'b0);
		// No stretch with the mode bit clear
		pmode = 4'h0;
		pin_req = 4'h1;
		cyc(1);
		pin_req = 4'h0;
		#1 chk(flt[0], 1'b0);
		// Latched status holds until cleared
		lmode = 4'h1;
		c0 = 4'hF;
		clr_pulse();
		pin_req = 4'h1;
		cyc(1);
		pin_req = 4'h0;
		cyc(3);
		chk(st0[3:0], 4'h1);
		pin_req = 4'h1;
		clr_pulse();
		cyc(1);
		chk(st0[3:0], 4'h1);
		pin_req = 4'h0;
		cyc(1);
		clr_pulse();
		cyc(1);
		chk(st0[3:0], 4'h0);
		// Every interrupt source of every generator
		gie = 4'hF;
		for (int k = 0; k < 24; k++)
		begin
			en = 24'h1 << k;
			ev = 24'h1 << k;
			cyc(1);
			ev = 24'h0;
			chk({raw, msk}, {24'h1 << k, 24'h1 << k});
			chk(line, 32'h1 << (k / 6));
			iclr = ~(24'h1 << k);
			cyc(1);
			iclr = 24'h0;
			en = 24'h0;
			#1 chk({raw, msk, line}, {24'h1 << k, 24'h0, 4'h0});
			cyc(1);
			iclr = 24'h1 << k;
			cyc(1);
			iclr = 24'h0;
			chk(raw, 32'h0);
		end
		// Clock enable low freezes the status
		ce = 1'b0;
		ev = 24'h2;
		cyc(1);
		ev = 24'h0;
		ce = 1'b1;
		#1 chk(raw, 24'h0);
		// Event beats a clear in the same cycle; module enable gates the line
		en = 24'hFFFFFF;
		ev = 24'h1;
		iclr = 24'h1;
		cyc(1);
		ev = 24'h0;
		iclr = 24'h0;
		gie = 4'h0;
		#1 chk({raw, msk, line}, {24'h1, 24'h1, 4'h0});
		end_of_test();
	end
endmodule
`default_nettype wire
